/* File: rtl/ssmd_datapath.sv */
`include "ssmd_defines.svh"
module ssmd_datapath import ssmd_pkg::*; (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Issue from decode
    input wire logic inValid,
    input wire ssmd_op_t opcode,
    input wire logic [7:0] imm8,
    input wire logic signedExt,
    // Register file operands
    input wire logic [127:0] destOp,
    input wire logic [127:0] srcOp,
    input wire logic [127:0] vecZero,
    // Writeback
    output logic resValid_reg,
    output logic [127:0] result_reg
);

    // ************************************
    // Element selection
    // ************************************
    function automatic logic [63:0] shufHalf(input logic [63:0] h, input logic [7:0] sel);
        logic [63:0] r;
        r = '0;
        for (int i = 0; i < 4; i++)
            r[16*i +: 16] = h[16*sel[2*i +: 2] +: 16];
        return r;
    endfunction

    function automatic logic [127:0] extend(input logic [127:0] s, input int fw, input int tw, input logic sgn);
        logic [127:0] r;
        r = '0;
        for (int i = 0; i < 128; i++)
        begin
            if (i % tw < fw)
                r[i] = s[(i / tw) * fw + i % tw];
            else
                r[i] = sgn & s[(i / tw) * fw + fw - 1];
        end
        return r;
    endfunction

    // Kind 0 is unsigned saturating subtract, kind 1 absolute value
    function automatic logic [127:0] laneArith(input logic [127:0] a, input logic [127:0] b,
                                                input int w, input logic kind);
        logic [127:0] r;
        logic [31:0] x;
        logic [31:0] y;
        logic [31:0] m;
        logic [31:0] v;
        r = '0;
        m = (w == 32) ? 32'hffff_ffff : ((32'h1 << w) - 32'h1);
        for (int n = 0; n < 16; n++)
        begin
            if (n * w < 128)
            begin
                x = 32'(a >> (n * w)) & m;
                y = 32'(b >> (n * w)) & m;
                if (kind)
                    v = x[w-1] ? ((32'h0 - x) & m) : x;
                else
                    v = (x > y) ? (x - y) : 32'h0;
                r = r | (128'(v) << (n * w));
            end
        end
        return r;
    endfunction

    // ************************************
    // Floating point helpers
    // ************************************
    // Operand sits in the low 32 bits for single precision
    function automatic logic [63:0] roundFp(input logic [63:0] x, input logic dp, input logic [1:0] mode);
        int bias;
        int man;
        int e;
        int k;
        logic sg;
        logic nz;
        logic inc;
        logic [63:0] fm;
        logic [63:0] rem;
        logic [63:0] half;
        bias = dp ? `SSMD_DP_BIAS : `SSMD_SP_BIAS;
        man = dp ? `SSMD_DP_MAN : `SSMD_SP_MAN;
        e = dp ? int'(x[62:52]) : int'(x[30:23]);
        sg = dp ? x[63] : x[31];
        nz = dp ? |x[62:0] : |x[30:0];
        inc = 1'b0;
        if (e >= bias + man)
            return x;
        if (e < bias)
        begin
            unique case (mode)
                `SSMD_RND_NEAR: inc = (e == bias - 1) && (dp ? |x[51:0] : |x[22:0]);
                `SSMD_RND_DOWN: inc = sg && nz;
                `SSMD_RND_UP: inc = !sg && nz;
                `SSMD_RND_TRUNC: inc = 1'b0;
            endcase
            return (dp ? {sg, 63'h0} : {32'h0, sg, 31'h0}) | (inc ? (dp ? `SSMD_DP_ONE : `SSMD_SP_ONE) : 64'h0);
        end
        k = bias + man - e;
        fm = (64'h1 << k) - 64'h1;
        rem = x & fm;
        half = 64'h1 << (k - 1);
        unique case (mode)
            `SSMD_RND_NEAR: inc = (rem > half) || ((rem == half) && x[k]);
            `SSMD_RND_DOWN: inc = sg && (rem != 64'h0);
            `SSMD_RND_UP: inc = !sg && (rem != 64'h0);
            `SSMD_RND_TRUNC: inc = 1'b0;
        endcase
        // Mantissa carry ripples into the exponent, which stays a valid encoding
        return (x & ~fm) + (inc ? (64'h1 << k) : 64'h0);
    endfunction

    // Truncating conversion; out of range gives the indefinite integer
    function automatic logic [31:0] fToInt(input logic [63:0] x, input logic dp);
        int bias;
        int man;
        int p;
        logic [63:0] m;
        bias = dp ? `SSMD_DP_BIAS : `SSMD_SP_BIAS;
        man = dp ? `SSMD_DP_MAN : `SSMD_SP_MAN;
        p = (dp ? int'(x[62:52]) : int'(x[30:23])) - bias;
        m = dp ? {11'h0, 1'b1, x[51:0]} : {40'h0, 1'b1, x[22:0]};
        if (p < 0)
            return 32'h0;
        if (p > 30)
            return `SSMD_INT_INDEF;
        m = (p >= man) ? (m << (p - man)) : (m >> (man - p));
        return (dp ? x[63] : x[31]) ? (32'h0 - m[31:0]) : m[31:0];
    endfunction

    // Single precision result truncates magnitudes wider than 24 bits
    function automatic logic [63:0] iToF(input logic [31:0] v, input logic dp);
        logic [31:0] mag;
        logic [63:0] f;
        int p;
        mag = v[31] ? (32'h0 - v) : v;
        p = 0;
        for (int i = 0; i < 32; i++)
            if (mag[i])
                p = i;
        if (v == 32'h0)
            return 64'h0;
        if (dp)
        begin
            f = {32'h0, mag} << (`SSMD_DP_MAN - p);
            return {v[31], 11'(`SSMD_DP_BIAS + p), f[51:0]};
        end
        f = (p >= `SSMD_SP_MAN) ? ({32'h0, mag} >> (p - `SSMD_SP_MAN)) : ({32'h0, mag} << (`SSMD_SP_MAN - p));
        return {32'h0, v[31], 8'(`SSMD_SP_BIAS + p), f[22:0]};
    endfunction

    // ************************************
    // Lane units
    // ************************************
    logic [1:0] rndMode;
    logic [127:0] rndPs;
    logic [127:0] rndPd;
    logic [127:0] cvtSpInt;
    logic [127:0] cvtIntSp;
    logic [127:0] cvtDpInt;
    logic [127:0] cvtIntDp;
    logic [127:0] dwShuf;
    logic [127:0] byteShuf;
    logic [127:0] blendRes;
    logic [127:0] resultNext;

    // Mode is taken from the immediate only; no global control is consulted
    assign rndMode = imm8[`SSMD_RND_LSB +: 2];
    assign cvtDpInt[127:64] = 64'h0;

    genvar g;
    generate
        for (g = 0; g < 4; g++)
        begin : gSp
            logic [63:0] rs;
            logic [63:0] cf;
            assign rs = roundFp({32'h0, srcOp[32*g +: 32]}, 1'b0, rndMode);
            assign cf = iToF(srcOp[32*g +: 32], 1'b0);
            assign rndPs[32*g +: 32] = rs[31:0];
            assign cvtIntSp[32*g +: 32] = cf[31:0];
            assign cvtSpInt[32*g +: 32] = fToInt({32'h0, srcOp[32*g +: 32]}, 1'b0);
            assign dwShuf[32*g +: 32] = srcOp[32*imm8[2*g +: 2] +: 32];
        end
        for (g = 0; g < 2; g++)
        begin : gDp
            assign rndPd[64*g +: 64] = roundFp(srcOp[64*g +: 64], 1'b1, rndMode);
            assign cvtDpInt[32*g +: 32] = fToInt(srcOp[64*g +: 64], 1'b1);
            assign cvtIntDp[64*g +: 64] = iToF(srcOp[32*g +: 32], 1'b1);
        end
        for (g = 0; g < 16; g++)
        begin : gByte
            logic [7:0] ctl;
            logic pick;
            assign ctl = srcOp[8*g +: 8];
            // Four-bit index cannot leave the operand
            assign byteShuf[8*g +: 8] = ctl[7] ? 8'h0 : destOp[8*ctl[3:0] +: 8];
            assign pick = (opcode == SSMD_BLEND_WORD_IMM) ? imm8[g/2] : vecZero[8*g+7];
            assign blendRes[8*g +: 8] = pick ? srcOp[8*g +: 8] : destOp[8*g +: 8];
        end
    endgenerate

    // ************************************
    // Result select
    // ************************************
    always_comb
    begin
        unique case (opcode)
            SSMD_LOW_HALF_WORD_SHUFFLE: resultNext = {srcOp[127:64], shufHalf(srcOp[63:0], imm8)};
            SSMD_HIGH_HALF_WORD_SHUFFLE: resultNext = {shufHalf(srcOp[127:64], imm8), srcOp[63:0]};
            SSMD_DWORD_SHUFFLE: resultNext = dwShuf;
            SSMD_BYTE_SHUFFLE: resultNext = byteShuf;
            SSMD_BLEND_WORD_IMM, SSMD_BLEND_BYTE_VAR: resultNext = blendRes;
            SSMD_LOW_QUAD_INTERLEAVE: resultNext = {srcOp[63:0], destOp[63:0]};
            SSMD_HIGH_QUAD_INTERLEAVE: resultNext = {srcOp[127:64], destOp[127:64]};
            SSMD_NARROW_TO_WIDE_MOVE: resultNext = {64'h0, srcOp[63:0]};
            SSMD_WIDE_TO_NARROW_MOVE: resultNext = {64'h0, srcOp[63:0]};
            SSMD_CVT_SP_TO_INT: resultNext = cvtSpInt;
            SSMD_CVT_INT_TO_SP: resultNext = cvtIntSp;
            SSMD_CVT_DP_TO_INT: resultNext = cvtDpInt;
            SSMD_CVT_INT_TO_DP: resultNext = cvtIntDp;
            SSMD_ROUND_PS: resultNext = rndPs;
            SSMD_ROUND_PD: resultNext = rndPd;
            SSMD_ROUND_SS: resultNext = {destOp[127:32], rndPs[31:0]};
            SSMD_ROUND_SD: resultNext = {destOp[127:64], rndPd[63:0]};
            SSMD_WIDEN_B_W: resultNext = extend(srcOp, 8, 16, signedExt);
            SSMD_WIDEN_B_D: resultNext = extend(srcOp, 8, 32, signedExt);
            SSMD_WIDEN_B_Q: resultNext = extend(srcOp, 8, 64, signedExt);
            SSMD_WIDEN_W_D: resultNext = extend(srcOp, 16, 32, signedExt);
            SSMD_WIDEN_W_Q: resultNext = extend(srcOp, 16, 64, signedExt);
            SSMD_WIDEN_D_Q: resultNext = extend(srcOp, 32, 64, signedExt);
            // No dword variant of the saturating subtract exists
            SSMD_SUBUS_B: resultNext = laneArith(destOp, srcOp, 8, 1'b0);
            SSMD_SUBUS_W: resultNext = laneArith(destOp, srcOp, 16, 1'b0);
            SSMD_ABS_B: resultNext = laneArith(srcOp, srcOp, 8, 1'b1);
            SSMD_ABS_W: resultNext = laneArith(srcOp, srcOp, 16, 1'b1);
            SSMD_ABS_D: resultNext = laneArith(srcOp, srcOp, 32, 1'b1);
            default: resultNext = destOp;
        endcase
    end

    // Only the destination value and its valid bit leave the block; no flag outputs exist
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            resValid_reg <= 1'b0;
            result_reg <= 128'h0;
        end
        else
        begin
            resValid_reg <= inValid;
            if (inValid)
                result_reg <= resultNext;
        end
    end

    // ************************************
    // Checks
    // ************************************
    a_valid_one_cycle: assert property (@(posedge clk) disable iff (rst)
        inValid |=> resValid_reg ##1 (resValid_reg == $past(inValid)))
        else $error("result valid not one cycle after issue");
    a_low_shuf_passthru: assert property (@(posedge clk) disable iff (rst)
        inValid && opcode == SSMD_LOW_HALF_WORD_SHUFFLE |=> result_reg[127:64] == $past(srcOp[127:64]))
        else $error("upper half altered by low word shuffle");
    a_high_shuf_word3: assert property (@(posedge clk) disable iff (rst)
        inValid && opcode == SSMD_HIGH_HALF_WORD_SHUFFLE && imm8[7:6] == 2'h2
        |=> result_reg[127:112] == $past(srcOp[111:96]))
        else $error("high word shuffle picked wrong word");
    a_dword_shuf_pos0: assert property (@(posedge clk) disable iff (rst)
        inValid && opcode == SSMD_DWORD_SHUFFLE && imm8[1:0] == 2'h3 |=> result_reg[31:0] == $past(srcOp[127:96]))
        else $error("dword shuffle position 0 wrong");
    a_byte_shuf_zero: assert property (@(posedge clk) disable iff (rst)
        inValid && opcode == SSMD_BYTE_SHUFFLE && srcOp[7] |=> result_reg[7:0] == 8'h0)
        else $error("byte shuffle did not zero byte");
    a_blend_var_keep: assert property (@(posedge clk) disable iff (rst)
        inValid && opcode == SSMD_BLEND_BYTE_VAR && !vecZero[127] |=> result_reg[127:120] == $past(destOp[127:120]))
        else $error("variable blend replaced unmasked byte");
    a_quad_lo_build: assert property (@(posedge clk) disable iff (rst)
        inValid && opcode == SSMD_LOW_QUAD_INTERLEAVE |=> result_reg == {$past(srcOp[63:0]), $past(destOp[63:0])})
        else $error("low quad interleave wrong");
    a_move_upper_zero: assert property (@(posedge clk) disable iff (rst)
        inValid && opcode == SSMD_NARROW_TO_WIDE_MOVE |=> result_reg[127:64] == 64'h0)
        else $error("narrow to wide move left upper bits");
    a_subus_clamp_zero: assert property (@(posedge clk) disable iff (rst)
        inValid && opcode == SSMD_SUBUS_W && destOp[15:0] < srcOp[15:0] |=> result_reg[15:0] == 16'h0)
        else $error("saturating subtract wrapped");
    a_abs_most_neg: assert property (@(posedge clk) disable iff (rst)
        inValid && opcode == SSMD_ABS_W && srcOp[15:0] == 16'h8000 |=> result_reg[15:0] == 16'h8000)
        else $error("most negative absolute value changed");
    c_byte_shuffle: cover property (@(posedge clk) disable iff (rst) inValid && opcode == SSMD_BYTE_SHUFFLE);
    c_round_ss: cover property (@(posedge clk) disable iff (rst) inValid && opcode == SSMD_ROUND_SS);
    c_back_to_back: cover property (@(posedge clk) disable iff (rst) inValid ##1 inValid);
endmodule

/* File: rtl/ssmd_defines.svh */
`ifndef SSMD_DEFINES_SVH
`define SSMD_DEFINES_SVH
// Contract
// - Word shuffles route any of four words of the chosen half anywhere in it.
// - The half not being shuffled is copied unchanged from the source.
// - Doubleword shuffle places any of four source dwords in any result position.
// - Immediate bits 1-0,3-2,5-4,7-6 select sources for positions 0,1,2,3.
// - Byte shuffle sources bytes only from the 16 bytes of one operand.
// - Blend works on bytes and words; mask-selected elements replaced, rest kept.
// - Blend mask comes from immediate or implicitly from vector register zero.
// - Quad interleave joins same-half of destination and source into destination.
// - The unselected source halves never influence an interleave result.
// - Narrow to wide move writes low half and clears upper 64 bits.
// - Wide to narrow move transfers only the low 64 source bits.
// - Convert four singles to/from int32, and doubles to/from int32.
// - Rounding mode comes from the instruction, never the global control register.
// - Rounded integral results stay encoded as floating point.
// - Widen bytes, words, dwords to larger lanes, with sign or zero extension.
// - Unsigned saturating subtract clamps each lane at zero.
// - Unsigned saturating subtract exists for byte and word lanes only.
// - Absolute value on 128 bits at byte, word and dword lanes.
// - Most negative lane value returns unchanged from absolute value.

// Rounding mode field of the immediate
`define SSMD_RND_LSB 0
`define SSMD_RND_NEAR 2'h0
`define SSMD_RND_DOWN 2'h1
`define SSMD_RND_UP 2'h2
`define SSMD_RND_TRUNC 2'h3
// Floating-point formats
`define SSMD_SP_BIAS 127
`define SSMD_SP_MAN 23
`define SSMD_DP_BIAS 1023
`define SSMD_DP_MAN 52
`define SSMD_SP_ONE 64'h0000_0000_3f80_0000
`define SSMD_DP_ONE 64'h3ff0_0000_0000_0000
`define SSMD_INT_INDEF 32'h8000_0000
`endif

/* File: rtl/ssmd_pkg.sv */
package ssmd_pkg;
    typedef enum logic [4:0] {
        SSMD_LOW_HALF_WORD_SHUFFLE, SSMD_HIGH_HALF_WORD_SHUFFLE, SSMD_DWORD_SHUFFLE, SSMD_BYTE_SHUFFLE,
        SSMD_BLEND_WORD_IMM, SSMD_BLEND_BYTE_VAR, SSMD_LOW_QUAD_INTERLEAVE, SSMD_HIGH_QUAD_INTERLEAVE,
        SSMD_NARROW_TO_WIDE_MOVE, SSMD_WIDE_TO_NARROW_MOVE,
        SSMD_CVT_SP_TO_INT, SSMD_CVT_INT_TO_SP, SSMD_CVT_DP_TO_INT, SSMD_CVT_INT_TO_DP,
        SSMD_ROUND_PS, SSMD_ROUND_PD, SSMD_ROUND_SS, SSMD_ROUND_SD,
        SSMD_WIDEN_B_W, SSMD_WIDEN_B_D, SSMD_WIDEN_B_Q, SSMD_WIDEN_W_D, SSMD_WIDEN_W_Q, SSMD_WIDEN_D_Q,
        SSMD_SUBUS_B, SSMD_SUBUS_W, SSMD_ABS_B, SSMD_ABS_W, SSMD_ABS_D, SSMD_NOP
    } ssmd_op_t;
endpackage

/* File: tb/ssmd_core_model.sv */
module ssmd_core_model import ssmd_pkg::*; (
    // Bench request
    input wire logic issueReq,
    input wire ssmd_op_t reqOp,
    input wire logic [7:0] reqImm,
    input wire logic reqSigned,
    input wire logic [127:0] reqDest,
    input wire logic [127:0] reqSrc,
    input wire logic [127:0] reqZero,
    // Issue to datapath
    output logic inValid,
    output ssmd_op_t opcode,
    output logic [7:0] imm8,
    output logic signedExt,
    output logic [127:0] destOp,
    output logic [127:0] srcOp,
    output logic [127:0] vecZero
);
    timeunit 1ns;
    timeprecision 1ps;
    // Idle read ports show inverted data, so sampling outside an issue shows up
    assign inValid = issueReq;
    assign opcode = issueReq ? reqOp : SSMD_NOP;
    assign imm8 = issueReq ? reqImm : ~reqImm;
    assign signedExt = issueReq ? reqSigned : ~reqSigned;
    assign destOp = issueReq ? reqDest : ~reqDest;
    assign srcOp = issueReq ? reqSrc : ~reqSrc;
    assign vecZero = issueReq ? reqZero : ~reqZero;
endmodule

/* File: tb/simd_shuffle_move_datapath_tb.sv */
module simd_shuffle_move_datapath_tb import ssmd_pkg::*; ();
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic issueReq = 1'b0;
    ssmd_op_t reqOp = SSMD_NOP;
    logic [7:0] reqImm = 8'h00;
    logic reqSigned = 1'b0;
    logic [127:0] reqDest = '0;
    logic [127:0] reqSrc = '0;
    logic [127:0] reqZero = '0;
    logic inValid, signedExt, resValid_reg;
    ssmd_op_t opcode;
    logic [7:0] imm8;
    logic [127:0] destOp, srcOp, vecZero, result_reg;
    int err_total = 0;
    int checks = 0;
    localparam logic [127:0] S0 = 128'hf0e1_d2c3_b4a5_9687_7869_5a4b_3c2d_1e0f;

    always #4 clk = ~clk;

    ssmd_core_model ssmd_core_model_inst (.issueReq(issueReq), .reqOp(reqOp), .reqImm(reqImm),
        .reqSigned(reqSigned), .reqDest(reqDest), .reqSrc(reqSrc), .reqZero(reqZero), .inValid(inValid),
        .opcode(opcode), .imm8(imm8), .signedExt(signedExt), .destOp(destOp), .srcOp(srcOp), .vecZero(vecZero));
    ssmd_datapath ssmd_datapath_inst (.clk(clk), .rst(rst), .inValid(inValid), .opcode(opcode), .imm8(imm8),
        .signedExt(signedExt), .destOp(destOp), .srcOp(srcOp), .vecZero(vecZero),
        .resValid_reg(resValid_reg), .result_reg(result_reg));

    // ****************
    // Helpers
    // ****************
    task automatic check(input logic [127:0] seen, input logic [127:0] exp);
        checks++;
        if (seen !== exp)
        begin
            err_total++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    function automatic logic [63:0] lane(input logic [127:0] v, input int i, input int w);
        lane = 64'((v >> (i * w)) & ((128'h1 << w) - 128'h1));
    endfunction

    function automatic logic [127:0] put(input logic [127:0] e, input int i, input int w, input logic [63:0] x);
        put = e | (({64'h0, x} & ((128'h1 << w) - 128'h1)) << (i * w));
    endfunction

    task automatic finish_test;
        if (err_total == 0 && checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // Result must appear exactly one edge after issue
    task automatic exec(input ssmd_op_t op, input logic [7:0] imm, input logic sx, input logic [127:0] d,
                        input logic [127:0] s, input logic [127:0] z, output logic [127:0] got);
        @(negedge clk);
        check({127'h0, resValid_reg}, 128'h0);
        reqOp = op;
        reqImm = imm;
        reqSigned = sx;
        reqDest = d;
        reqSrc = s;
        reqZero = z;
        issueReq = 1'b1;
        @(negedge clk);
        issueReq = 1'b0;
        check({127'h0, resValid_reg}, 128'h1);
        got = result_reg;
    endtask

    // ****************
    // Scenarios
    // ****************
    task automatic t_shuffle;
        logic [127:0] e, g;
        logic [7:0] imms [4] = '{8'h1b, 8'h00, 8'he4, 8'h9c};
        foreach (imms[k])
        begin
            e = S0;
            for (int p = 0; p < 4; p++)
                e[p*16 +: 16] = S0[imms[k][p*2 +: 2]*16 +: 16];
            exec(SSMD_LOW_HALF_WORD_SHUFFLE, imms[k], 1'b0, ~S0, S0, '0, g);
            check(g, e);
            e = S0;
            for (int p = 0; p < 4; p++)
                e[64+p*16 +: 16] = S0[64+imms[k][p*2 +: 2]*16 +: 16];
            exec(SSMD_HIGH_HALF_WORD_SHUFFLE, imms[k], 1'b0, ~S0, S0, '0, g);
            check(g, e);
            for (int p = 0; p < 4; p++)
                e[p*32 +: 32] = S0[imms[k][p*2 +: 2]*32 +: 32];
            exec(SSMD_DWORD_SHUFFLE, imms[k], 1'b0, ~S0, S0, '0, g);
            check(g, e);
        end
    endtask

    task automatic t_bytes;
        logic [127:0] c = 128'h8f0e_7d1c_2b3a_4958_6776_8594_a3b2_c180;
        logic [127:0] z = 128'h0080_ff7f_0180_00ff_8001_7f80_0000_ffff;
        logic [127:0] e, g;
        for (int i = 0; i < 16; i++)
            e[i*8 +: 8] = c[i*8+7] ? 8'h00 : S0[c[i*8 +: 4]*8 +: 8];
        exec(SSMD_BYTE_SHUFFLE, 8'h00, 1'b0, S0, c, '0, g);
        check(g, e);
        for (int i = 0; i < 8; i++)
            e[i*16 +: 16] = (8'ha5 >> i) & 1 ? c[i*16 +: 16] : S0[i*16 +: 16];
        exec(SSMD_BLEND_WORD_IMM, 8'ha5, 1'b0, S0, c, ~z, g);
        check(g, e);
        for (int i = 0; i < 16; i++)
            e[i*8 +: 8] = z[i*8+7] ? c[i*8 +: 8] : S0[i*8 +: 8];
        exec(SSMD_BLEND_BYTE_VAR, 8'h5a, 1'b0, S0, c, z, g);
        check(g, e);
        exec(SSMD_LOW_QUAD_INTERLEAVE, 8'h00, 1'b0, S0, c, '0, g);
        check(g, {c[63:0], S0[63:0]});
        exec(SSMD_HIGH_QUAD_INTERLEAVE, 8'h00, 1'b0, S0, c, '0, g);
        check(g, {c[127:64], S0[127:64]});
        exec(SSMD_NARROW_TO_WIDE_MOVE, 8'h00, 1'b0, S0, c, '0, g);
        check(g, {64'h0, c[63:0]});
        exec(SSMD_WIDE_TO_NARROW_MOVE, 8'h00, 1'b0, S0, c, '0, g);
        check(g, {64'h0, c[63:0]});
    endtask

    task automatic t_arith;
        logic [127:0] d = 128'h00ff_7f80_1234_8000_ffff_0001_aaaa_5555;
        logic [127:0] s = 128'h0100_7f7f_1235_7fff_0001_ffff_5555_aaaa;
        logic [127:0] a = 128'h8000_0000_7fff_ffff_ff80_7f01_ffff_8000;
        ssmd_op_t wop [6] = '{SSMD_WIDEN_B_W, SSMD_WIDEN_B_D, SSMD_WIDEN_B_Q, SSMD_WIDEN_W_D,
                              SSMD_WIDEN_W_Q, SSMD_WIDEN_D_Q};
        int ws [6] = '{8, 8, 8, 16, 16, 32};
        int wd [6] = '{16, 32, 64, 32, 64, 64};
        logic [127:0] e, g;
        logic [63:0] x, y;
        for (int w = 8; w <= 16; w *= 2)
        begin
            e = '0;
            for (int i = 0; i < 128 / w; i++)
                e = put(e, i, w, lane(d, i, w) > lane(s, i, w) ? lane(d, i, w) - lane(s, i, w) : 64'h0);
            exec(w == 8 ? SSMD_SUBUS_B : SSMD_SUBUS_W, 8'h00, 1'b0, d, s, '0, g);
            check(g, e);
        end
        for (int w = 8; w <= 32; w *= 2)
        begin
            e = '0;
            for (int i = 0; i < 128 / w; i++)
            begin
                x = lane(a, i, w);
                e = put(e, i, w, x[w-1] ? ~x + 64'h1 : x);
            end
            exec(w == 8 ? SSMD_ABS_B : (w == 16 ? SSMD_ABS_W : SSMD_ABS_D), 8'h00, 1'b0, d, a, '0, g);
            check(g, e);
        end
        for (int j = 0; j < 6; j++)
            for (int sx = 0; sx < 2; sx++)
            begin
                e = '0;
                for (int i = 0; i < 128 / wd[j]; i++)
                begin
                    y = lane(a, i, ws[j]);
                    x = (sx == 1 && y[ws[j]-1]) ? y | ~((64'h1 << ws[j]) - 64'h1) : y;
                    e = put(e, i, wd[j], x);
                end
                exec(wop[j], 8'h00, sx[0], d, a, '0, g);
                check(g, e);
            end
    endtask

    task automatic t_float;
        logic [127:0] s = 128'h3e800000_bfc00000_40200000_3fc00000;
        logic [127:0] r [4] = '{128'h00000000_c0000000_40000000_40000000, 128'h00000000_c0000000_40000000_3f800000,
                                128'h3f800000_bf800000_40400000_40000000, 128'h00000000_bf800000_40000000_3f800000};
        logic [127:0] dp = 128'hbff8000000000000_4004000000000000;
        logic [127:0] g;
        for (int m = 0; m < 4; m++)
        begin
            exec(SSMD_ROUND_PS, 8'(m), 1'b0, ~s, s, '0, g);
            check(g, r[m]);
        end
        exec(SSMD_CVT_SP_TO_INT, 8'h00, 1'b0, S0, 128'h42c80000_40700000_c0000000_3f800000, '0, g);
        check(g, 128'h00000064_00000003_fffffffe_00000001);
        exec(SSMD_CVT_INT_TO_SP, 8'h00, 1'b0, S0, 128'h00000064_00000003_fffffffe_00000001, '0, g);
        check(g, 128'h42c80000_40400000_c0000000_3f800000);
        exec(SSMD_CVT_INT_TO_DP, 8'h00, 1'b0, S0, 128'h00000064_00000003_fffffffe_00000001, '0, g);
        check(g, 128'hc000000000000000_3ff0000000000000);
        exec(SSMD_CVT_DP_TO_INT, 8'h00, 1'b0, S0, dp, '0, g);
        check(g, 128'h00000000_00000000_ffffffff_00000002);
        exec(SSMD_ROUND_PD, 8'h00, 1'b0, S0, dp, '0, g);
        check(g, 128'hc000000000000000_4000000000000000);
        exec(SSMD_ROUND_SD, 8'h02, 1'b0, S0, dp, '0, g);
        check(g, {S0[127:64], 64'h4008000000000000});
        exec(SSMD_ROUND_SS, 8'h01, 1'b0, S0, s, '0, g);
        check(g, {S0[127:32], 32'h3f800000});
    endtask

    // Two issues on consecutive edges, then the last result must stand
    task automatic t_b2b;
        @(negedge clk);
        reqOp = SSMD_LOW_QUAD_INTERLEAVE;
        reqDest = S0;
        reqSrc = ~S0;
        issueReq = 1'b1;
        @(negedge clk);
        check(result_reg, {~S0[63:0], S0[63:0]});
        reqOp = SSMD_NOP;
        reqDest = 128'h1;
        @(negedge clk);
        issueReq = 1'b0;
        check({127'h0, resValid_reg}, 128'h1);
        check(result_reg, 128'h1);
        @(negedge clk);
        check({127'h0, resValid_reg}, 128'h0);
        check(result_reg, 128'h1);
    endtask

    // ****************
    // Main sequence
    // ****************
    initial
    begin
        repeat (16) @(negedge clk);
        rst = 1'b0;
        @(negedge clk);
        check({127'h0, resValid_reg}, 128'h0);
        check(result_reg, 128'h0);
        t_shuffle();
        t_bytes();
        t_arith();
        t_float();
        t_b2b();
        finish_test();
    end

    // Hang guard
    initial
    begin
        repeat (5000) @(posedge clk);
        err_total++;
        finish_test();
    end
endmodule
